/* File: logic/sgc_top.sv */
// Gate command selector: internal burst regulator, external command, sleep and limits.
//
// Function
// (R1) Active command input drives gate, not regulator.
// (R2) Command idle past timeout returns to regulator.
// (R3) Five fast pulses stop switching, enter sleep.
// (R4) Wake on new command pulses or supply-low lockout.
// (R5) Partner sends 20-65 kHz varying-duty command.
// (R6) Sixteen regulator periods per oscillator period.
// (R7) Oscillator gates only regulator-driven switching.
// (R8) Blank comparators at every on-time start.
// (R9) Peak-limit trip ends on-time, both modes.
// (R10) Window-limit counts only in window after blanking.
// (R11) Window-limit trip in window ends on-time.
// (R12) External commands accepted only with bias ready.
// (R13) Internal: trip, fixed off-time, auto restart.
// (R14) External: after trip wait next rising command.
// (R15) Regulator drives only after supply-low lockout releases.
// (R16) Supply-high lockout forces gate off always.
// (R17) Synchronise comparators, lockouts, command input.
// (R18) Sleep holds gate low, stops burst sequencing.
`timescale 1ns/1ps
`default_nettype none

module sgc_top
    import sgc_pkg::*;
#(
    parameter logic [15:0] CMD_LOSS_CYC = CMD_LOSS_CYC_DEF,
    parameter logic [23:0] OSC_PERIOD_CYC = OSC_PERIOD_CYC_DEF
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Asynchronous pin-side and analog indications
    input wire logic pwm_command,
    input wire logic peak_limit_comparator,
    input wire logic window_limit_comparator,
    input wire logic supply_low_lockout,
    input wire logic supply_high_lockout,
    input wire logic bias_ready,
    // Gate drive and status
    output logic gate_drive,
    output logic ext_mode,
    output logic sleep_mode,
    output logic low_rate_burst_oscillator
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    sgc_state_s q;
    sgc_state_s d;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic pwm;
        logic peak;
        logic win;
        logic low_lock;
        logic high_lock;
        logic bias;
        logic rise;
        logic fall;
        logic edge_seen;
        logic short_lvl;
        logic burst_seen;
        logic loss;
        logic blank;
        logic in_window;
        logic trip;
        logic allowed;
        logic burst_open;

        d = q;
        pwm = 1'b0;
        peak = 1'b0;
        win = 1'b0;
        low_lock = 1'b0;
        high_lock = 1'b0;
        bias = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        edge_seen = 1'b0;
        short_lvl = 1'b0;
        burst_seen = 1'b0;
        loss = 1'b0;
        blank = 1'b0;
        in_window = 1'b0;
        trip = 1'b0;
        allowed = 1'b0;
        burst_open = 1'b0;

        // Only the second stage is read by the logic below.
        d.sync1[SY_PWM] = pwm_command; // see (R17)
        d.sync1[SY_PEAK] = peak_limit_comparator;
        d.sync1[SY_WIN] = window_limit_comparator;
        d.sync1[SY_LOW] = supply_low_lockout;
        d.sync1[SY_HIGH] = supply_high_lockout;
        d.sync1[SY_BIAS] = bias_ready;
        d.sync2 = q.sync1; // see (R17)

        pwm = q.sync2[SY_PWM];
        peak = q.sync2[SY_PEAK];
        win = q.sync2[SY_WIN];
        low_lock = q.sync2[SY_LOW];
        high_lock = q.sync2[SY_HIGH];
        bias = q.sync2[SY_BIAS];

        d.pwm_prev = pwm;
        rise = pwm & ~q.pwm_prev;
        fall = ~pwm & q.pwm_prev;
        edge_seen = rise | fall;

        // Cycles since the last command edge, saturating; serves loss and burst detection.
        if (edge_seen) begin
            d.edge_cnt = '0;
        end else if (q.edge_cnt != EDGE_CNT_MAX) begin
            d.edge_cnt = q.edge_cnt + 16'h0001;
        end
        loss = (q.edge_cnt >= CMD_LOSS_CYC); // see (R2)

        // A level is short when the edge that ends it comes within the burst limit.
        short_lvl = (q.edge_cnt < SLEEP_LVL_CYC);
        if (edge_seen) begin
            if (!short_lvl) begin
                d.short_cnt = '0;
            end else if (q.short_cnt != SLEEP_SHORT_LVLS) begin
                d.short_cnt = q.short_cnt + 4'h1;
            end
        end
        burst_seen = edge_seen && short_lvl
            && (q.short_cnt == SLEEP_SHORT_LVLS - 4'h1); // see (R3)

        // Mode selection.
        case (q.mode)
            SGC_MD_INT: begin
                if (burst_seen) begin
                    d.mode = SGC_MD_SLEEP; // see (R3)
                end else if (rise && bias) begin
                    d.mode = SGC_MD_EXT; // see (R1) (R12)
                end
            end
            SGC_MD_EXT: begin
                if (burst_seen) begin
                    d.mode = SGC_MD_SLEEP; // see (R3)
                end else if (loss || !bias) begin
                    d.mode = SGC_MD_INT; // see (R2) (R12)
                end
            end
            SGC_MD_SLEEP: begin
                if (low_lock) begin
                    d.mode = SGC_MD_INT; // see (R4)
                end else if (rise) begin
                    d.mode = bias ? SGC_MD_EXT : SGC_MD_INT; // see (R4) (R12)
                end
            end
            default: begin
                d.mode = SGC_MD_INT;
            end
        endcase

        // Burst oscillator; frozen at the start of its period while asleep.
        if (q.mode == SGC_MD_SLEEP) begin
            d.osc_cnt = '0; // see (R18)
            d.burst_cnt = '0;
        end else if (q.osc_cnt >= OSC_PERIOD_CYC - OSC_CNT_ONE) begin
            d.osc_cnt = '0;
            d.burst_cnt = '0; // see (R6)
        end else begin
            d.osc_cnt = q.osc_cnt + OSC_CNT_ONE;
        end
        burst_open = (q.burst_cnt < BURST_PULSES); // see (R6)

        // Blanking and window timing counted from each on-time start.
        blank = (q.on_cnt < BLANK_CYC); // see (R8)
        in_window = !blank && (q.on_cnt < BLANK_WIN_END); // see (R10)
        trip = q.gate && !blank && (peak || (in_window && win)); // see (R9) (R11)
        if (q.gate && q.on_cnt != ON_CNT_MAX) begin
            d.on_cnt = q.on_cnt + 8'h01;
        end

        // Lockouts override every command source.
        allowed = !high_lock && !low_lock; // see (R15) (R16)

        if (q.mode == SGC_MD_INT) begin
            if (q.gate) begin
                if (trip) begin
                    d.gate = 1'b0; // see (R13)
                    d.off_cnt = OFF_CYC;
                end
            end else if (q.off_cnt != '0) begin
                d.off_cnt = q.off_cnt - 10'h001; // see (R13)
            end else if (burst_open && allowed) begin
                d.gate = 1'b1; // see (R13) (R7)
                d.on_cnt = '0;
                // Counted on top of a wrap in this cycle, so a new period starts at one.
                d.burst_cnt = d.burst_cnt + 5'h01; // see (R6)
            end
        end else if (q.mode == SGC_MD_EXT) begin
            // The oscillator plays no part here; the command times the gate, and a limit trip can end the on-time early.
            if (q.gate) begin
                if (trip || fall) begin
                    d.gate = 1'b0; // see (R14) (R1)
                end
            end else if (rise && allowed) begin
                d.gate = 1'b1; // see (R1) (R14)
                d.on_cnt = '0;
            end
        end else begin
            d.gate = 1'b0; // see (R18)
        end

        // A mode change or a lockout ends any on-time and restarts the off-time.
        if (d.mode != q.mode || !allowed) begin
            d.gate = 1'b0; // see (R16) (R15)
            d.off_cnt = OFF_CYC;
        end
        if (d.mode == SGC_MD_SLEEP) begin
            d.gate = 1'b0; // see (R3) (R18)
        end

        d.ext_flag = (d.mode == SGC_MD_EXT);
        d.sleep_flag = (d.mode == SGC_MD_SLEEP);
        d.osc_flag = (d.mode != SGC_MD_SLEEP) && (d.burst_cnt < BURST_PULSES);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign gate_drive = q.gate;
    assign ext_mode = q.ext_flag;
    assign sleep_mode = q.sleep_flag;
    assign low_rate_burst_oscillator = q.osc_flag;

endmodule

`default_nettype wire

/* File: inc/sgc_pkg.sv */
// Constants, state encoding and state record for the start-up gate command selector.
package sgc_pkg;

    // Clock rate of mclk in MHz.
    localparam int CLK_MHZ = 20;

    // Leading-edge blanking time in ns; a least time, rounded up.
    localparam int BLANK_NS = 240;
    localparam int BLANK_CYC_I = (BLANK_NS * CLK_MHZ + 999) / 1000;
    // Window-limit sensing interval after blanking in ns; rounded up.
    localparam int WIN_NS = 166;
    localparam int WIN_CYC_I = (WIN_NS * CLK_MHZ + 999) / 1000;
    // Fixed regulator off-time in us.
    localparam int OFF_US = 21;
    localparam int OFF_CYC_I = OFF_US * CLK_MHZ;
    // Command-loss timeout in us; the cycle count is a top parameter.
    localparam int CMD_LOSS_US = 260;
    localparam int CMD_LOSS_CYC_I = CMD_LOSS_US * CLK_MHZ;
    // Longest high or low level of a sleep-burst pulse in ns; rounded down.
    localparam int SLEEP_LVL_NS = 1100;
    localparam int SLEEP_LVL_CYC_I = (SLEEP_LVL_NS * CLK_MHZ) / 1000;
    // Default low-rate oscillator frequency in Hz; the period is a top parameter.
    localparam int OSC_HZ = 100;
    localparam int OSC_PERIOD_CYC_I = (CLK_MHZ * 1000000) / OSC_HZ;

    localparam logic [7:0] BLANK_CYC = 8'(BLANK_CYC_I);
    localparam logic [7:0] BLANK_WIN_END = 8'(BLANK_CYC_I + WIN_CYC_I);
    localparam logic [7:0] ON_CNT_MAX = 8'hff;
    localparam logic [9:0] OFF_CYC = 10'(OFF_CYC_I);
    localparam logic [15:0] CMD_LOSS_CYC_DEF = 16'(CMD_LOSS_CYC_I);
    localparam logic [15:0] EDGE_CNT_MAX = 16'hffff;
    localparam logic [15:0] SLEEP_LVL_CYC = 16'(SLEEP_LVL_CYC_I);
    localparam logic [23:0] OSC_PERIOD_CYC_DEF = 24'(OSC_PERIOD_CYC_I);
    localparam logic [23:0] OSC_CNT_ONE = 24'h000001;

    // Regulator periods per oscillator period.
    localparam logic [4:0] BURST_PULSES = 5'h10;
    // Five burst pulses give nine short levels between their ten edges.
    localparam logic [3:0] SLEEP_SHORT_LVLS = 4'h9;

    // Bit positions inside the synchroniser vectors.
    localparam int SY_PWM = 0;
    localparam int SY_PEAK = 1;
    localparam int SY_WIN = 2;
    localparam int SY_LOW = 3;
    localparam int SY_HIGH = 4;
    localparam int SY_BIAS = 5;
    localparam int SY_W = 6;

    typedef enum logic [1:0] {
        SGC_MD_INT = 2'b00,
        SGC_MD_EXT = 2'b01,
        SGC_MD_SLEEP = 2'b10
    } sgc_mode_e;

    typedef struct packed {
        logic [SY_W-1:0] sync1;
        logic [SY_W-1:0] sync2;
        logic pwm_prev;
        sgc_mode_e mode;
        logic gate;
        logic [7:0] on_cnt;
        logic [9:0] off_cnt;
        logic [4:0] burst_cnt;
        logic [23:0] osc_cnt;
        logic [15:0] edge_cnt;
        logic [3:0] short_cnt;
        logic ext_flag;
        logic sleep_flag;
        logic osc_flag;
    } sgc_state_s;

endpackage

/* File: tb/sgc_chk.sv */
// Port-level checks for the gate selector, bound into its top module.
`timescale 1ns/1ps
`default_nettype none
module sgc_chk #(
    parameter logic [15:0] CMD_LOSS_CYC = 16'h0000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Watched pins
    input wire logic pwm_command,
    input wire logic supply_low_lockout,
    input wire logic supply_high_lockout,
    input wire logic gate_drive,
    input wire logic ext_mode,
    input wire logic sleep_mode,
    input wire logic low_rate_burst_oscillator
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic [15:0] idle_q;
    logic pwm_q;
    // Idle time is counted at the pin, so sync latency shows up as slack below.
    always_ff @(posedge mclk) begin
        pwm_q <= pwm_command;
        if (rst || pwm_q != pwm_command) begin
            idle_q <= 16'h0000;
        end else if (idle_q != 16'hffff) begin
            idle_q <= idle_q + 16'h0001;
        end
    end
    sequence s_int_start;
        $rose(gate_drive) && !ext_mode;
    endsequence
    sequence s_ext_start;
        $rose(gate_drive) && ext_mode;
    endsequence
    a_high_lock_off: assert property (supply_high_lockout [*5] |-> !gate_drive)
        else $error("gate on under supply-high lockout");
    a_low_lock_off: assert property (supply_low_lockout [*5] |-> !gate_drive)
        else $error("gate on under supply-low lockout");
    a_sleep_gate_low: assert property (sleep_mode |-> !gate_drive)
        else $error("gate on in sleep");
    a_sleep_osc_stop: assert property (
        sleep_mode && $past(sleep_mode) |-> !low_rate_burst_oscillator)
        else $error("burst phase active in sleep");
    a_blank_hold: assert property (
        s_int_start |=> (gate_drive || ext_mode || sleep_mode) [*3])
        else $error("on-time ended inside blanking");
    a_ext_rise: assert property (
        s_ext_start |-> $past(pwm_command, 3) && !$past(pwm_command, 8))
        else $error("external gate rise without command rise");
    a_ext_fall: assert property (ext_mode && $fell(pwm_command) |-> ##[1:4] !gate_drive)
        else $error("gate not released after command fall");
    a_loss_revert: assert property (
        ext_mode && idle_q == CMD_LOSS_CYC - 16'h0002 |-> ##[3:10] !ext_mode)
        else $error("command loss not detected in time");
endmodule
bind sgc_top sgc_chk #(.CMD_LOSS_CYC(CMD_LOSS_CYC)) u_chk (.mclk(mclk), .rst(rst),
    .pwm_command(pwm_command), .supply_low_lockout(supply_low_lockout),
    .supply_high_lockout(supply_high_lockout), .gate_drive(gate_drive), .ext_mode(ext_mode),
    .sleep_mode(sleep_mode), .low_rate_burst_oscillator(low_rate_burst_oscillator));
`default_nettype wire

/* File: tb/sgc_partner.sv */
// Secondary-side command source: plain PWM or a five-pulse sleep burst.
`timescale 1ns/1ps
`default_nettype none
module sgc_partner (
    // Clock and control
    input wire logic mclk,
    input wire logic run,
    input wire logic sleep_req,
    input wire logic [9:0] hi_c,
    input wire logic [9:0] per_c,
    // Command pin
    output logic pwm_command
);
    int cnt = 0;
    int nb = 0;
    initial pwm_command = 1'b0;
    always @(posedge mclk) begin
        if (nb > 0) begin
            nb <= nb - 1;
            pwm_command <= ((nb - 1) / 12) % 2 == 1;
        end else if (sleep_req) begin
            nb <= 120;
        end else if (run) begin
            cnt <= (cnt + 1 >= per_c) ? 0 : cnt + 1;
            pwm_command <= cnt < hi_c;
        end else begin
            cnt <= 0;
            pwm_command <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/startup_gate_command_selector_tb_top.sv */
// Self-checking bench for the gate selector with a command source model.
`timescale 1ns/1ps
`default_nettype none
module startup_gate_command_selector_tb_top;
    import sgc_pkg::*;
    localparam logic [15:0] LOSS = 16'h05dc;
    localparam logic [23:0] OSC_P = 24'h002328;
    logic mclk, rst, pwm_command, peak, win, low_lk, high_lk, bias, run, slp, gprev;
    logic gate_drive, ext_mode, sleep_mode, osc;
    logic [9:0] hi_c, per_c;
    logic [4:0] outs;
    logic [31:0] seed = 32'h67e26a84;
    logic pq[$];
    logic mdl_on = 1'b0;
    int miscompares = 0, n_tests = 0, cyc = 0, t = 0, rises = 0, tnum = 0;
    assign outs = {pwm_command, sleep_mode, ext_mode, osc, gate_drive};
    sgc_top #(.CMD_LOSS_CYC(LOSS), .OSC_PERIOD_CYC(OSC_P)) uut (.mclk(mclk), .rst(rst),
        .pwm_command(pwm_command), .peak_limit_comparator(peak), .window_limit_comparator(win),
        .supply_low_lockout(low_lk), .supply_high_lockout(high_lk), .bias_ready(bias),
        .gate_drive(gate_drive), .ext_mode(ext_mode), .sleep_mode(sleep_mode),
        .low_rate_burst_oscillator(osc));
    sgc_partner u_partner (.mclk(mclk), .run(run), .sleep_req(slp), .hi_c(hi_c),
        .per_c(per_c), .pwm_command(pwm_command));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_on(input int sel, input logic v, input int lim);
        t = 0;
        while (outs[sel] !== v && t < lim) begin
            @(posedge mclk);
            t++;
        end
    endtask
    task automatic fin;
        tnum++;
        $display("test %0d ended", tnum);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Rising gate edges, counted for burst and sleep checks.
    always @(posedge mclk) begin
        gprev <= gate_drive;
        // Reference model: with the comparators quiet, the gate repeats the command three edges late.
        if (pq.size() == 3) begin
            if (mdl_on)
                check(gate_drive, pq[0]);
            void'(pq.pop_front());
        end
        pq.push_back(pwm_command);
        if (gate_drive === 1'b1 && gprev === 1'b0)
            rises++;
        cyc++;
        if (cyc == 100000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        gprev = 1'b0;
        {peak, win, low_lk, high_lk, bias, run, slp} = 7'h00;
        hi_c = 10'h0c8;
        per_c = 10'h190;
        tick(4);
        rst <= 1'b0;
        peak <= 1'b1;
        wait_on(0, 1, 50);
        wait_on(0, 0, 50);
        check(t >= BLANK_CYC_I, 1);
        wait_on(0, 1, 600);
        check(t, OFF_CYC_I + 1);
        wait_on(1, 0, 20000);
        wait_on(1, 1, 20000);
        rises = 0;
        tick(OSC_P - 10);
        check(rises, BURST_PULSES);
        fin();
        peak <= 1'b0;
        win <= 1'b1;
        wait_on(0, 1, 3000);
        wait_on(0, 0, 50);
        check(t < BLANK_WIN_END + 4, 1);
        win <= 1'b0;
        wait_on(0, 1, 600);
        tick(12);
        win <= 1'b1;
        tick(10);
        check(gate_drive, 1);
        peak <= 1'b1;
        wait_on(0, 0, 20);
        check(t < 6, 1);
        win <= 1'b0;
        fin();
        for (int k = 0; k < 2; k++) begin
            peak <= 1'b0;
            wait_on(0, 1, 10000);
            tick(10);
            high_lk <= (k == 0);
            low_lk <= (k == 1);
            wait_on(0, 0, 20);
            check(t <= 6, 1);
            tick(40);
            check(gate_drive, 0);
            {high_lk, low_lk} <= 2'b00;
        end
        fin();
        run <= 1'b1;
        tick(3000);
        check(ext_mode, 0);
        bias <= 1'b1;
        wait_on(2, 1, 2100);
        check(ext_mode, 1);
        for (int i = 0; i < 6; i++) begin
            mdl_on = (i > 0) && (i < 3);
            seed = xs(seed);
            per_c <= 10'(320 + seed % 600);
            hi_c <= 10'(60 + (seed >> 12) % 200);
            peak <= (i > 2);
            wait_on(4, 0, 1100);
            tick(6);
            mdl_on = (i < 3);
            check(gate_drive, 0);
            wait_on(4, 1, 1100);
            tick(20);
            check(gate_drive, !peak);
        end
        run <= 1'b0;
        tick(LOSS - 10);
        check(ext_mode, 1);
        tick(30);
        check(ext_mode, 0);
        fin();
        for (int j = 0; j < 2; j++) begin
            slp <= 1'b1;
            tick(1);
            slp <= 1'b0;
            tick(140);
            check(sleep_mode, 1);
            rises = 0;
            tick(3000);
            check({rises[3:0], osc}, 5'h00);
            if (j == 0) begin
                low_lk <= 1'b1;
                wait_on(3, 0, 8);
                low_lk <= 1'b0;
            end else begin
                run <= 1'b1;
                wait_on(3, 0, 1100);
            end
            check(sleep_mode, 0);
        end
        fin();
        close_out();
    end
endmodule
`default_nettype wire
